// [src/sdct_pkg.sv]
/*
 Shared constants and carrier types of the SDRAM command timing block.
 Assumes a 40 MHz core clock and a controller that samples nothing here.
*/
package sdct_pkg;
   localparam int unsigned CLK_PERIOD_PS            = 25000;
   localparam int unsigned POWER_DOWN_ENTRY_LATENCY = 1;
   localparam int unsigned POWER_DOWN_EXIT_LATENCY  = 1;
   localparam int unsigned WRITE_MASK_LATENCY       = 0;
   localparam int unsigned READ_MASK_FLOAT_LATENCY  = 2;
   localparam int unsigned WRITE_COMMAND_DATA_DELAY = 0;
   localparam int unsigned DATA_WIDTH               = 16;
   localparam int unsigned MASK_WIDTH               = 2;
   localparam int unsigned ADDR_WIDTH               = 4;

   typedef enum logic [2:0]
   {
      SDCT_CMD_NOP   = 3'h0,
      SDCT_CMD_READ  = 3'h1,
      SDCT_CMD_WRITE = 3'h2,
      SDCT_CMD_OTHER = 3'h3
   } sdct_cmd_t;

   typedef struct packed
   {
      sdct_cmd_t                   cmd;
      logic [ADDR_WIDTH-1:0]       col;
      logic [MASK_WIDTH-1:0]       mask;
      logic [DATA_WIDTH-1:0]       wdata;
   } sdct_bus_t;

   typedef enum logic [1:0]
   {
      SDCT_ST_RUN   = 2'h0,
      SDCT_ST_SLEEP = 2'h1
   } sdct_state_t;
endpackage : sdct_pkg

// [src/sdct_mem.sv]
/*
 Small byte-masked word memory with registered read data.
 Assumes one write and one read port on the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sdct_mem
   import sdct_pkg::*;
#(
   parameter int unsigned AW = ADDR_WIDTH
)
(
   input  wire logic                  core_clk,
   input  wire logic                  we,
   input  wire logic [AW-1:0]         waddr,
   input  wire logic [MASK_WIDTH-1:0] wen_byte,
   input  wire logic [DATA_WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]         raddr,
   output var  logic [DATA_WIDTH-1:0] rdata
);
   logic [DATA_WIDTH-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < MASK_WIDTH; i++)
      begin
         if (we && wen_byte[i])
            mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
      rdata <= mem[raddr];
   end
endmodule : sdct_mem
`default_nettype wire

// [src/sdct_core.sv]
/*
 Device-side command timing core: clock-enable power-down, byte masks, write capture.
 Assumes the controller meets all command spacing; inputs are synchronous logic.
*/
`timescale 1ns/100ps
`default_nettype none
module sdct_core
   import sdct_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_enable,
   input  var  sdct_bus_t             bus_in,
   output var  logic [DATA_WIDTH-1:0] rdata,
   output var  logic [DATA_WIDTH-1:0] rdata_oe,
   output var  logic                  suspended
);
   sdct_state_t           state;
   sdct_state_t           next_state;
   logic                  active;
   logic                  next_suspended;
   logic [MASK_WIDTH-1:0] rmask_d1;
   logic [MASK_WIDTH-1:0] next_rmask_d1;
   logic                  rd_d1;
   logic                  next_rd_d1;
   logic [DATA_WIDTH-1:0] mem_q;
   logic [DATA_WIDTH-1:0] next_rdata_oe;
   logic                  we;

   function automatic logic [DATA_WIDTH-1:0] lanes(input logic [MASK_WIDTH-1:0] m);
      logic [DATA_WIDTH-1:0] r;
      r = '0;
      for (int i = 0; i < MASK_WIDTH; i++)
         r[i*8 +: 8] = {8{m[i]}};
      return r;
   endfunction : lanes

   // Commands only count one edge after the clock enable sampled high
   assign active = (state == SDCT_ST_RUN);

   always_comb
   begin
      next_state     = clk_enable ? SDCT_ST_RUN : SDCT_ST_SLEEP;
      // Own flop for the flag, so the pin carries no decode after the state
      next_suspended = (next_state == SDCT_ST_SLEEP);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state     <= SDCT_ST_RUN;
         suspended <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         suspended <= next_suspended;
      end
   end

   // Data and mask arrive with the command; no extra stage on writes
   assign we = active && (bus_in.cmd == SDCT_CMD_WRITE);

   sdct_mem u_mem
   (
      .core_clk (core_clk),
      .we       (we),
      .waddr    (bus_in.col),
      .wen_byte (~bus_in.mask),
      .wdata    (bus_in.wdata),
      .raddr    (bus_in.col),
      .rdata    (mem_q)
   );

   always_comb
   begin
      next_rd_d1    = active && (bus_in.cmd == SDCT_CMD_READ);
      next_rmask_d1 = active ? bus_in.mask : rmask_d1;
      // Mask from one edge back, taken with the read, gates the drivers
      next_rdata_oe = rd_d1 ? ~lanes(rmask_d1) : '0;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rd_d1    <= 1'b0;
         rmask_d1 <= '0;
         rdata_oe <= '0;
         rdata    <= '0;
      end
      else
      begin
         rd_d1    <= next_rd_d1;
         rmask_d1 <= next_rmask_d1;
         rdata_oe <= next_rdata_oe;
         rdata    <= mem_q;
      end
   end

   sequence s_read;
      active && bus_in.cmd == SDCT_CMD_READ;
   endsequence

   sequence s_write;
      active && bus_in.cmd == SDCT_CMD_WRITE;
   endsequence

   sequence s_masked_read;
      active && bus_in.cmd == SDCT_CMD_READ && bus_in.mask[0];
   endsequence

   sequence s_asleep_read;
      suspended && bus_in.cmd == SDCT_CMD_READ;
   endsequence

   // Waking edge, then a write in the first running cycle
   sequence s_wake_write;
      suspended && clk_enable ##1 active && bus_in.cmd == SDCT_CMD_WRITE && !bus_in.mask[0];
   endsequence

   a_sleep_entry : assert property (@(posedge core_clk) disable iff (sys_rst)
      !clk_enable
      |=> suspended)
      else $error("not suspended one clock after enable low");

   a_sleep_exit : assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_enable
      |=> !suspended)
      else $error("not resumed one clock after enable high");

   a_read_float : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_masked_read
      |-> ##2 rdata_oe[7:0] == 8'h00)
      else $error("masked read lane driven");

   a_read_drive : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_read ##0 !bus_in.mask[0]
      |-> ##2 rdata_oe[7:0] == 8'hff)
      else $error("unmasked read lane floating");

   a_float_high : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_read ##0 bus_in.mask[1]
      |-> ##2 rdata_oe[15:8] == 8'h00)
      else $error("masked upper read lane driven");

   a_drive_high : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_read ##0 !bus_in.mask[1]
      |-> ##2 rdata_oe[15:8] == 8'hff)
      else $error("unmasked upper read lane floating");

   a_read_word : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_read
      |-> ##2 rdata == $past(u_mem.mem[bus_in.col], 2))
      else $error("read data differs from stored word");

   a_write_lands : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_write ##0 !bus_in.mask[0]
      |=> u_mem.mem[$past(bus_in.col)][7:0] == $past(bus_in.wdata[7:0]))
      else $error("write data not captured on command edge");

   a_write_high : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_write ##0 !bus_in.mask[1]
      |=> u_mem.mem[$past(bus_in.col)][15:8] == $past(bus_in.wdata[15:8]))
      else $error("upper write data not captured on command edge");

   a_mask_keeps : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_write ##0 bus_in.mask[0]
      |=> u_mem.mem[$past(bus_in.col)][7:0] == $past(u_mem.mem[bus_in.col][7:0]))
      else $error("masked byte written");

   a_mask_high : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_write ##0 bus_in.mask[1]
      |=> u_mem.mem[$past(bus_in.col)][15:8] == $past(u_mem.mem[bus_in.col][15:8]))
      else $error("masked upper byte written");

   a_sleep_hold : assert property (@(posedge core_clk) disable iff (sys_rst)
      suspended
      |=> u_mem.mem[$past(bus_in.col)] == $past(u_mem.mem[bus_in.col]))
      else $error("write accepted while suspended");

   a_sleep_read : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_asleep_read
      |-> ##2 rdata_oe == '0)
      else $error("read answered while suspended");

   a_wake_write : assert property (@(posedge core_clk) disable iff (sys_rst)
      s_wake_write
      |=> u_mem.mem[$past(bus_in.col)][7:0] == $past(bus_in.wdata[7:0]))
      else $error("first write after wake lost");

   a_oe_idle : assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(rd_d1)
      |-> rdata_oe == '0)
      else $error("outputs driven without read");

   // Checked through reset, so no disable here
   a_reset_quiet : assert property (@(posedge core_clk)
      sys_rst
      |=> rdata_oe == '0 && !suspended)
      else $error("outputs not quiet after reset");
endmodule : sdct_core
`default_nettype wire

// [verif/sdct_ctrl_model.sv]
/*
 Controller model: launches commands and clock enable toward the device.
 Assumes the bench sets requests after rising edges; launch is on falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module sdct_ctrl_model
   import sdct_pkg::*;
(
   input  wire logic      core_clk,
   input  var  sdct_bus_t req,
   input  wire logic      req_ce,
   output var  sdct_bus_t bus_out,
   output var  logic      ce_out
);
   // Only reads, writes and no-ops go out: row, refresh and mode-load spacing hold by omission
   // Half a cycle of margin both ways; write data rides with its command
   always @(negedge core_clk)
   begin
      bus_out <= req;
      ce_out  <= req_ce;
   end
endmodule : sdct_ctrl_model
`default_nettype wire

// [verif/testbench.sv]
/*
 Self-checking bench: random masked writes and reads, power-down entry and exit.
 Assumes the controller model in sdct_ctrl_model.sv drives the device pins.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sdct_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  sys_rst  = 1'b1;
   sdct_bus_t             req      = '0;
   logic                  req_ce   = 1'b1;
   sdct_bus_t             bus_in;
   logic                  clk_enable;
   logic [DATA_WIDTH-1:0] rdata;
   logic [DATA_WIDTH-1:0] rdata_oe;
   logic                  suspended;
   logic [DATA_WIDTH-1:0] exp_mem [16];
   int                    n_mismatch  = 0;
   int                    check_count = 0;
   always #12.5 core_clk = ~core_clk;
   sdct_ctrl_model i_ctrl (.core_clk(core_clk), .req(req), .req_ce(req_ce), .bus_out(bus_in),
                           .ce_out(clk_enable));
   sdct_core i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_enable(clk_enable), .bus_in(bus_in),
                    .rdata(rdata), .rdata_oe(rdata_oe), .suspended(suspended));
   function automatic logic [DATA_WIDTH-1:0] lanes(input logic [MASK_WIDTH-1:0] m);
      return {{8{~m[1]}}, {8{~m[0]}}};
   endfunction : lanes
   task automatic check(input string what, input logic [DATA_WIDTH-1:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic step(input sdct_cmd_t c, input logic [3:0] a, input logic [1:0] m, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      req = '{c, a, m, d};
   endtask : step
   task automatic write(input logic [3:0] a, input logic [1:0] m, input logic [15:0] d);
      step(SDCT_CMD_WRITE, a, m, d);
      exp_mem[a] = (exp_mem[a] & ~lanes(m)) | (d & lanes(m));
   endtask : write
   // Answer launches one edge after the read is taken, is seen at the second, stands one cycle
   task automatic read_chk(input logic [3:0] a, input logic [1:0] m);
      step(SDCT_CMD_READ, a, m, 16'($urandom));
      step(SDCT_CMD_NOP, 4'h0, 2'h0, 16'h0);
      @(posedge core_clk);
      #1;
      check("rdata_oe", rdata_oe, lanes(m));
      check("rdata", rdata & rdata_oe, exp_mem[a] & lanes(m));
   endtask : read_chk
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   initial
   begin
      logic [3:0] a;
      logic [1:0] m;
      void'($urandom(47286));
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      check("suspended", {15'h0, suspended}, 16'h0);
      check("rdata_oe", rdata_oe, 16'h0);
      for (int i = 0; i < 16; i++) write(4'(i), 2'h0, 16'($urandom));
      for (int i = 0; i < 4; i++)
      begin
         write(4'h3, 2'(i), 16'($urandom));
         read_chk(4'h3, 2'(3 - i));
      end
      $display("Test masks done");
      repeat (200)
      begin
         a = 4'($urandom_range(15));
         m = 2'($urandom);
         if ($urandom_range(1) == 1)
            write(a, m, 16'($urandom));
         else
            read_chk(a, m);
      end
      $display("Test random done");
      step(SDCT_CMD_NOP, 4'h0, 2'h0, 16'h0);
      req_ce = 1'b0;
      @(posedge core_clk);
      #1;
      check("suspended", {15'h0, suspended}, 16'h1);
      // A write, then a read, both refused while asleep
      req = '{SDCT_CMD_WRITE, 4'h7, 2'h0, ~exp_mem[7]};
      step(SDCT_CMD_READ, 4'h7, 2'h0, 16'h0);
      req_ce = 1'b1;
      check("suspended", {15'h0, suspended}, 16'h1);
      @(posedge core_clk);
      #1;
      check("suspended", {15'h0, suspended}, 16'h0);
      exp_mem[5] = ~exp_mem[5];
      req = '{SDCT_CMD_WRITE, 4'h5, 2'h0, exp_mem[5]};
      @(posedge core_clk);
      #1;
      check("rdata_oe", rdata_oe, 16'h0);
      req.cmd = SDCT_CMD_NOP;
      read_chk(4'h5, 2'h0);
      read_chk(4'h7, 2'h0);
      $display("Test power done");
      test_done();
   end
   // Whole run is some 450 cycles; about nine times that means a hang
   initial
   begin
      #100us;
      n_mismatch++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
